// File: rtl/mcc_defines.svh
// Functional notes
// (R1) Core ratio codes 0-4 decode; 5-7 reserved
// (R2) Core PLL fed by memory clock
// (R3) Core ratio select resets to zero
// (R4) Memory ratio resets zero: 2x, one: 3x
// (R5) Memory PLL fed by external reference
// (R6) Core PLL off bit resets to one
// (R7) Core bypass resets one: core from memory
// (R8) Memory PLL off bit resets to one
// (R9) Memory bypass resets one: external reference
// (R10) Both bypassed: core runs at reference rate
// (R11) Boot never selects a disabled PLL output
// (R12) Boot should enable both PLLs
// (R13) Refresh interval resets to decimal 1000
// (R14) Rank size resets 4 MB; 0, 7 reserved
// (R15) Memory interface held in reset during load
// (R16) After release, readable but not writable
// (R17) Memory PLL not disabled while selected
// (R18) Reserved codes flagged as invalid
`ifndef MCC_DEFINES_SVH
`define MCC_DEFINES_SVH

// Register selects on the boot and read ports
`define MCC_SEL_MEM_CFG      1'b0
`define MCC_SEL_RATIO_CFG    1'b1

// memory_config field layout
`define MCC_REFRESH_LSB      16
`define MCC_REFRESH_MSB      31
`define MCC_SIZE_LSB         4
`define MCC_SIZE_MSB         6
`define MCC_MEM_CFG_MASK     32'hffff_0070
`define MCC_MEM_CFG_RESET    32'h03e8_0040

// clock_ratio_config field layout
`define MCC_CRATIO_LSB       0
`define MCC_CRATIO_MSB       2
`define MCC_MRATIO_BIT       4
`define MCC_CORE_OFF_BIT     8
`define MCC_CORE_BYP_BIT     9
`define MCC_MEM_OFF_BIT      10
`define MCC_MEM_BYP_BIT      11
`define MCC_RATIO_CFG_MASK   32'h0000_0f17
`define MCC_RATIO_CFG_RESET  32'h0000_0f00

// Encodings
`define MCC_CRATIO_MAX       3'h4
`define MCC_SIZE_MIN         3'h1
`define MCC_SIZE_MAX         3'h6

`endif

// File: rtl/mcc_pkg.sv
package mcc_pkg;

    typedef enum logic [0:0]
    {
        MCC_BOOT = 1'b0,
        MCC_RUN  = 1'b1
    } mcc_state_t;

    // Core clock source seen by the core logic
    typedef enum logic [1:0]
    {
        MCC_SRC_EXT_REF  = 2'b00,
        MCC_SRC_MEM_PLL  = 2'b01,
        MCC_SRC_CORE_PLL = 2'b10
    } mcc_src_t;

    typedef struct packed
    {
        mcc_state_t  state;
        logic [31:0] mem_cfg;
        logic [31:0] ratio_cfg;
        logic [31:0] rd_data;
        logic        rd_valid;
    } mcc_regs_t;

endpackage

// File: rtl/mcc_top.sv
`timescale 1ns/1ps
`include "mcc_defines.svh"

module mcc_top
(
    input  wire logic            clock_i,
    input  wire logic            rst_b_i,
    input  wire logic            boot_wr_i,
    input  wire logic            boot_sel_i,
    input  wire logic [31:0]     boot_data_i,
    input  wire logic            boot_done_i,
    input  wire logic            rd_en_i,
    input  wire logic            rd_sel_i,
    output logic [31:0]          rd_data_o,
    output logic                 rd_valid_o,
    output logic                 mem_if_rst_o,
    output logic [2:0]           core_ratio_num_o,
    output logic [2:0]           core_ratio_den_o,
    output logic [1:0]           mem_ratio_mult_o,
    output logic                 core_pll_en_o,
    output logic                 core_pll_bypass_o,
    output logic                 mem_pll_en_o,
    output logic                 mem_pll_bypass_o,
    output mcc_pkg::mcc_src_t    core_clk_src_o,
    output logic [15:0]          refresh_interval_o,
    output logic [2:0]           rank_size_sel_o,
    output logic                 config_err_o
);
    import mcc_pkg::*;

    mcc_regs_t   r_q;
    mcc_regs_t   r_d;
    logic [2:0]  cratio;
    logic        mratio;
    logic        core_off;
    logic        core_byp;
    logic        mem_off;
    logic        mem_byp;
    logic [2:0]  size;

    ////////////////////////////////////////////////////////////////////////
    // Field extraction
    assign cratio   = r_q.ratio_cfg[`MCC_CRATIO_MSB:`MCC_CRATIO_LSB];
    assign mratio   = r_q.ratio_cfg[`MCC_MRATIO_BIT];
    assign core_off = r_q.ratio_cfg[`MCC_CORE_OFF_BIT];
    assign core_byp = r_q.ratio_cfg[`MCC_CORE_BYP_BIT];
    assign mem_off  = r_q.ratio_cfg[`MCC_MEM_OFF_BIT];
    assign mem_byp  = r_q.ratio_cfg[`MCC_MEM_BYP_BIT];
    assign size     = r_q.mem_cfg[`MCC_SIZE_MSB:`MCC_SIZE_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Next state: boot load window, then locked
    always_comb
    begin
        r_d          = r_q;
        r_d.rd_valid = 1'b0;
        case (r_q.state)
            MCC_BOOT:
            begin
                // Loads only while the memory interface sits in reset
                if (boot_wr_i)
                begin
                    if (boot_sel_i == `MCC_SEL_MEM_CFG)
                    begin
                        r_d.mem_cfg = boot_data_i
                                      & `MCC_MEM_CFG_MASK; // R15
                    end
                    else
                    begin
                        r_d.ratio_cfg = boot_data_i
                                        & `MCC_RATIO_CFG_MASK; // R15
                    end
                end
                if (boot_done_i)
                begin
                    r_d.state = MCC_RUN; // R15
                end
            end
            MCC_RUN:
            begin
                // No write path exists here; values are frozen
                r_d.state = MCC_RUN; // R16
            end
            default:
            begin
                r_d.state = MCC_BOOT;
            end
        endcase
        // Reads are allowed in either state
        if (rd_en_i)
        begin
            r_d.rd_valid = 1'b1; // R16
            r_d.rd_data  = (rd_sel_i == `MCC_SEL_MEM_CFG) ?
                           r_q.mem_cfg : r_q.ratio_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; defaults are the documented power-up values
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            r_q.state     <= MCC_BOOT;
            r_q.mem_cfg   <= `MCC_MEM_CFG_RESET;   // R13 R14
            r_q.ratio_cfg <= `MCC_RATIO_CFG_RESET; // R3 R4 R6 R7 R8 R9
            r_q.rd_data   <= 32'h0000_0000;
            r_q.rd_valid  <= 1'b0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core ratio decode; reserved codes fall back to 1:1
    always_comb
    begin
        case (cratio)
            3'h0:
            begin
                core_ratio_num_o = 3'h1; // R1
                core_ratio_den_o = 3'h1;
            end
            3'h1:
            begin
                core_ratio_num_o = 3'h2; // R1
                core_ratio_den_o = 3'h1;
            end
            3'h2:
            begin
                core_ratio_num_o = 3'h3; // R1
                core_ratio_den_o = 3'h2;
            end
            3'h3:
            begin
                core_ratio_num_o = 3'h4; // R1
                core_ratio_den_o = 3'h3;
            end
            3'h4:
            begin
                core_ratio_num_o = 3'h5; // R1
                core_ratio_den_o = 3'h4;
            end
            default:
            begin
                core_ratio_num_o = 3'h1; // R18
                core_ratio_den_o = 3'h1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock tree controls
    assign mem_ratio_mult_o  = mratio ? 2'h3 : 2'h2; // R4 R5
    assign core_pll_en_o     = ~core_off;            // R6
    assign mem_pll_en_o      = ~mem_off;             // R8
    assign core_pll_bypass_o = core_byp;             // R7
    assign mem_pll_bypass_o  = mem_byp;              // R9

    // Core source: core PLL output, else its input (the memory clock),
    // which is the reference itself when the memory PLL is bypassed
    always_comb
    begin
        if (!core_byp)
        begin
            core_clk_src_o = MCC_SRC_CORE_PLL; // R2
        end
        else if (mem_byp)
        begin
            core_clk_src_o = MCC_SRC_EXT_REF;  // R10
        end
        else
        begin
            core_clk_src_o = MCC_SRC_MEM_PLL;  // R2 R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory configuration and sanity flag
    assign refresh_interval_o =
        r_q.mem_cfg[`MCC_REFRESH_MSB:`MCC_REFRESH_LSB]; // R13
    assign rank_size_sel_o = size;                      // R14

    // Flags a loaded setting that clock or memory control cannot honour
    assign config_err_o = (cratio > `MCC_CRATIO_MAX)
                        | (size < `MCC_SIZE_MIN)
                        | (size > `MCC_SIZE_MAX)        // R18
                        | (core_off & ~core_byp)        // R11
                        | (mem_off & ~mem_byp);         // R17

    assign mem_if_rst_o = (r_q.state == MCC_BOOT);      // R15
    assign rd_data_o    = r_q.rd_data;
    assign rd_valid_o   = r_q.rd_valid;

endmodule

// File: verification/mcc_monitor.sv
`timescale 1ns/1ps
// Port checks for the clock and boot control block
module mcc_monitor
(
    input wire logic              clock_i,
    input wire logic              rst_b_i,
    input wire logic              boot_done_i,
    input wire logic              rd_en_i,
    input wire logic              rd_valid_o,
    input wire logic              mem_if_rst_o,
    input wire logic              core_pll_en_o,
    input wire logic              core_pll_bypass_o,
    input wire logic              mem_pll_en_o,
    input wire logic              mem_pll_bypass_o,
    input wire mcc_pkg::mcc_src_t core_clk_src_o,
    input wire logic [15:0]       refresh_interval_o,
    input wire logic              config_err_o
);
    import mcc_pkg::*;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////
    // Boot end is the only way out of memory reset
    sequence s_release;
        mem_if_rst_o && boot_done_i;
    endsequence
    a_release_ok: assert property (s_release |=> !mem_if_rst_o)
        else $error("release missed");
    a_held_reset: assert property (
        mem_if_rst_o && !boot_done_i |=> mem_if_rst_o)
        else $error("left reset early");
    // Reads answer once, a cycle later
    a_read_answer: assert property (rd_en_i |=> rd_valid_o)
        else $error("read not answered");
    a_read_single: assert property (!rd_en_i |=> !rd_valid_o)
        else $error("stray read valid");
    // Refresh interval frozen once running
    a_frozen_cfg: assert property (
        !mem_if_rst_o |=> $stable(refresh_interval_o))
        else $error("setting changed");
    // Clock source follows the bypass bits; a disabled PLL left unbypassed is flagged
    a_core_src: assert property (
        !core_pll_bypass_o |-> core_clk_src_o == MCC_SRC_CORE_PLL)
        else $error("core source wrong");
    a_ext_src: assert property (
        core_pll_bypass_o && mem_pll_bypass_o
        |-> core_clk_src_o == MCC_SRC_EXT_REF)
        else $error("ext source wrong");
    a_bad_combo: assert property (
        !core_pll_en_o && !core_pll_bypass_o |-> config_err_o)
        else $error("combo not flagged");
    a_mem_combo: assert property (
        !mem_pll_en_o && !mem_pll_bypass_o |-> config_err_o)
        else $error("mem combo not flagged");
endmodule

// File: verification/mcc_boot_rom.sv
`timescale 1ns/1ps
// Boot memory: both words, then end of boot
module mcc_boot_rom
(
    input  wire logic        clock_i,
    input  wire logic        go_i,
    input  wire logic        raw_i,
    input  wire logic [31:0] mem_w_i,
    input  wire logic [31:0] rat_w_i,
    output logic             wr_o,
    output logic             sel_o,
    output logic [31:0]      data_o,
    output logic             done_o
);
    ////////////////////////////////////////////////////////////
    // Raw mode skips the PLL clean-up to provoke the flag
    always
    begin
        wr_o = 1'b0;
        done_o = 1'b0;
        sel_o = 1'b0;
        data_o = 32'h0;
        @(posedge go_i);
        @(negedge clock_i);
        wr_o = 1'b1;
        data_o = mem_w_i;
        @(negedge clock_i);
        sel_o = 1'b1;
        data_o = raw_i ? rat_w_i : rat_w_i & 32'hffff_faff;
        @(negedge clock_i);
        wr_o = 1'b0;
        done_o = 1'b1;
        data_o = ~data_o;
        @(negedge clock_i);
    end
endmodule

// File: verification/mcc_tb_top.sv
`timescale 1ns/1ps
`include "mcc_defines.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module mcc_tb_top;
    import mcc_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        go = 1'b0;
    logic        raw = 1'b0;
    logic        rd_en_i = 1'b0;
    logic        rd_sel_i = 1'b0;
    logic [31:0] mem_w = 32'h0;
    logic [31:0] rat_w = 32'h0;
    logic [31:0] data, rd_data_o, em, er;
    logic        wr, sel, done, rd_valid_o, mem_if_rst_o, err, e_err;
    logic [2:0]  num, den;
    logic [1:0]  mult;
    logic        c_en, c_byp, m_en, m_byp;
    logic [15:0] refr;
    logic [2:0]  rsize;
    mcc_src_t    src, e_src;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          k, t;
    // 10 MHz clock
    always #50 clock_i = ~clock_i;
    mcc_boot_rom rom_u (.clock_i, .go_i(go), .raw_i(raw), .mem_w_i(mem_w),
        .rat_w_i(rat_w), .wr_o(wr), .sel_o(sel), .data_o(data), .done_o(done));
    mcc_top dut_u (.clock_i, .rst_b_i, .boot_wr_i(wr), .boot_sel_i(sel),
        .boot_data_i(data), .boot_done_i(done), .rd_en_i, .rd_sel_i,
        .rd_data_o, .rd_valid_o, .mem_if_rst_o, .core_ratio_num_o(num),
        .core_ratio_den_o(den), .mem_ratio_mult_o(mult),
        .core_pll_en_o(c_en), .core_pll_bypass_o(c_byp),
        .mem_pll_en_o(m_en), .mem_pll_bypass_o(m_byp),
        .core_clk_src_o(src), .refresh_interval_o(refr),
        .rank_size_sel_o(rsize),
        .config_err_o(err));
    ////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic reset_dut;
        @(negedge clock_i);
        rst_b_i = 1'b0;
        repeat (10) @(negedge clock_i);
        rst_b_i = 1'b1;
    endtask
    // Power-up values of every clock and memory control output
    task automatic chk_defaults;
        `CHK(mem_if_rst_o, 1'b1)
        `CHK(src, MCC_SRC_EXT_REF)
        `CHK(num, 3'h1)
        `CHK(den, 3'h1)
        `CHK(mult, 2'h2)
        `CHK(c_en, 1'b0)
        `CHK(c_byp, 1'b1)
        `CHK(m_en, 1'b0)
        `CHK(m_byp, 1'b1)
        `CHK(refr, 16'd1000)
        `CHK(rsize, 3'h4)
    endtask
    task automatic rd_chk(input logic s, input logic [31:0] e);
        @(negedge clock_i);
        rd_en_i = 1'b1;
        rd_sel_i = s;
        @(negedge clock_i);
        rd_en_i = 1'b0;
        `CHK(rd_valid_o, 1'b1)
        `CHK(rd_data_o, e)
    endtask
    // Bounded wait: a stuck reset ends the run
    task automatic boot;
        @(negedge clock_i);
        go = 1'b1;
        @(negedge clock_i);
        go = 1'b0;
        for (t = 0; t < 8 && mem_if_rst_o; t++)
            @(negedge clock_i);
        if (mem_if_rst_o !== 1'b0)
        begin
            $display("[FAIL] %0t boot release timed out", $time);
            n_mismatch++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        k = $urandom(89);
        reset_dut();
        chk_defaults();
        rd_chk(`MCC_SEL_MEM_CFG, 32'h03e8_0040);
        rd_chk(`MCC_SEL_RATIO_CFG, 32'h0000_0f00);
        // Every ratio code, fresh reset and boot each
        for (k = 0; k < 8; k++)
        begin
            raw = (k == 2 || k == 3);
            mem_w = $urandom;
            rat_w = ($urandom & 32'h0000_0f10) | k;
            // First two passes load a reserved rank size on purpose
            if (k < 2)
                mem_w[6:4] = 3'(k * 7);
            // Raw words break one PLL rule each, size kept legal
            if (raw)
                mem_w[6:4] = 3'h3;
            if (k == 2)
                rat_w = (rat_w & 32'hffff_f6ff) | 32'h400;
            if (k == 3)
                rat_w = (rat_w & 32'hffff_f9ff) | 32'h100;
            em = mem_w & `MCC_MEM_CFG_MASK;
            er = raw ? rat_w : rat_w & 32'hffff_faff;
            e_src = !er[9] ? MCC_SRC_CORE_PLL
                : er[11] ? MCC_SRC_EXT_REF : MCC_SRC_MEM_PLL;
            e_err = k > 4 || em[6:4] == 0 || em[6:4] == 7
                || (er[8] && !er[9]) || (er[10] && !er[11]);
            reset_dut();
            chk_defaults();
            boot();
            `CHK(num, k > 4 ? 3'h1 : 3'(k + 1))
            `CHK(den, (k < 2 || k > 4) ? 3'h1 : 3'(k))
            `CHK(mult, er[4] ? 2'h3 : 2'h2)
            `CHK(src, e_src)
            `CHK(err, e_err)
            `CHK(c_en, !er[8])
            `CHK(c_byp, er[9])
            `CHK(m_en, !er[10])
            `CHK(m_byp, er[11])
            `CHK(refr, em[31:16])
            `CHK(rsize, em[6:4])
            // Late words must be ignored
            mem_w = ~mem_w;
            rat_w = rat_w ^ 32'h0000_0f17;
            boot();
            repeat (3) @(negedge clock_i);
            rd_chk(`MCC_SEL_MEM_CFG, em);
            rd_chk(`MCC_SEL_RATIO_CFG, er);
        end
        end_sim();
    end
endmodule
bind mcc_top mcc_monitor mon_u (.clock_i, .rst_b_i, .boot_done_i, .rd_en_i,
    .rd_valid_o, .mem_if_rst_o, .core_pll_en_o, .core_pll_bypass_o,
    .mem_pll_en_o,
    .mem_pll_bypass_o, .core_clk_src_o, .refresh_interval_o, .config_err_o);
